// ---- bench/ibf_peer.sv ----
`timescale 1ns/1ps
module ibf_peer
(
   input wire logic aclk,
   output logic scl_pull,
   output logic sda_pull
);
   // Open drain: high grounds the wire, low lets the pull-up win
   initial
   begin
      scl_pull = 1'b0;
      sda_pull = 1'b0;
   end

   // One half period of the 80 ns link clock, four system cycles
   task automatic drive(input logic c, input logic d);
      @(posedge aclk);
      scl_pull <= !c;
      sda_pull <= !d;
      repeat (3) @(posedge aclk);
   endtask

   // SDA falls while SCL is high, then SCL goes low
   task automatic start_cond();
      drive(1'b1, 1'b1);
      drive(1'b1, 1'b0);
      drive(1'b0, 1'b0);
   endtask

   // Data set up during SCL low, then SCL left high
   task automatic send_bit(input logic b);
      drive(1'b0, b);
      drive(1'b1, b);
   endtask
endmodule

// ---- bench/ibf_top_monitor.sv ----
`timescale 1ns/1ps
`include "ibf_params.svh"
module ibf_top_monitor
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire ibf_pkg::ibf_resp_t s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire ibf_pkg::ibf_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire ibf_pkg::ibf_word_t s_axi_rdata,
   input wire ibf_pkg::ibf_resp_t s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic scl_i,
   input wire logic sda_i,
   input wire logic scl_oe,
   input wire logic sda_oe
);
   import ibf_pkg::*;
   logic [9:0] hi_cnt; // Cycles SCL has been high, saturating
   logic [3:0] edge_cnt; // Cycles since the last SCL change
   logic scl_d; // SCL one cycle ago
   logic rx_cap; // SDA at the last SCL rise
   logic rx_seen; // A rise has happened since reset
   ibf_addr_t rd_addr; // Address of the read under way
   logic mapped;
   assign mapped = rd_addr == `IBF_ADDR_CTRL || rd_addr == `IBF_ADDR_DATA || rd_addr == `IBF_ADDR_CFG;

   // Raw wire history; the design's synchroniser lags this by a few cycles
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         hi_cnt <= 10'h000;
         edge_cnt <= 4'h0;
         scl_d <= 1'b1;
         rx_cap <= 1'b0;
         rx_seen <= 1'b0;
         rd_addr <= '0;
      end
      else
      begin
         scl_d <= scl_i;
         hi_cnt <= !scl_i ? 10'h000 : (hi_cnt == 10'h3FF ? hi_cnt : hi_cnt + 10'h001);
         edge_cnt <= (scl_i != scl_d) ? 4'h0 : (edge_cnt == 4'hF ? edge_cnt : edge_cnt + 4'h1);
         // Received bit follows SDA at every rise
         if (scl_i && !scl_d)
         begin
            rx_cap <= sda_i;
            rx_seen <= 1'b1;
         end
         if (s_axi_arvalid && s_axi_arready)
            rd_addr <= s_axi_araddr;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_wr_answer;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_rd_answer;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   property p_rresp;
      s_axi_rvalid |-> s_axi_rresp == (mapped ? `IBF_RESP_OKAY : `IBF_RESP_SLVERR);
   endproperty
   a_rresp: assert property (p_rresp) else $error("read response code wrong");
   property p_data_low;
      s_axi_rvalid && rd_addr == `IBF_ADDR_DATA |-> (s_axi_rdata & 32'hFFFFFF7F) == 32'h00000000;
   endproperty
   a_data_low: assert property (p_data_low) else $error("data low bits not zero");
   property p_attn;
      s_axi_rvalid && rd_addr == `IBF_ADDR_CTRL |-> s_axi_rdata[6] == (|s_axi_rdata[5:2]);
   endproperty
   a_attn: assert property (p_attn) else $error("attention not OR of flags");
   property p_rxbit;
      s_axi_rvalid && rx_seen && edge_cnt >= 4'h8 && rd_addr inside {`IBF_ADDR_CTRL, `IBF_ADDR_DATA}
         |-> s_axi_rdata[7] == rx_cap;
   endproperty
   a_rxbit: assert property (p_rxbit) else $error("received bit wrong");
   property p_sda_setup;
      $rose(sda_oe) && scl_i |-> hi_cnt >= 10'd470;
   endproperty
   a_sda_setup: assert property (p_sda_setup) else $error("SDA pulled during short SCL high");
   property p_scl_high;
      $rose(scl_oe) && $past(scl_i) |-> hi_cnt >= 10'd470;
   endproperty
   a_scl_high: assert property (p_scl_high) else $error("SCL high phase short");
endmodule
bind ibf_top ibf_top_monitor ibf_top_monitor_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .scl_i, .sda_i,
   .scl_oe, .sda_oe);

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "ibf_params.svh"
module testbench;
   import ibf_pkg::*;
   localparam ibf_addr_t a_ctl = `IBF_ADDR_CTRL;
   localparam ibf_addr_t a_dat = `IBF_ADDR_DATA;
   localparam ibf_addr_t a_cfg = `IBF_ADDR_CFG;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   ibf_addr_t awaddr = '0;
   ibf_addr_t araddr = '0;
   ibf_word_t wdata = '0;
   ibf_strb_t wstrb = '0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, scl_pull, sda_pull, scl_o, sda_o;
   ibf_word_t rdata;
   ibf_resp_t bresp, rresp, rs;
   ibf_word_t rd; // Last read word
   // Wired-AND with pull-ups
   wire logic scl_w = !((scl_oe & !scl_o) | scl_pull);
   wire logic sda_w = !((sda_oe & !sda_o) | sda_pull);
   int mismatches = 0;
   int n_checks = 0;

   always #5 aclk = ~aclk;

   ibf_top ibf_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe));
   ibf_peer ibf_peer_i (.aclk(aclk), .scl_pull(scl_pull), .sda_pull(sda_pull));

   task automatic give_verdict();
      if (mismatches == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask

   // A hang ends the run at once
   task automatic hang(input string what);
      mismatches++;
      $display("MISMATCH %s expected answer seen timeout", what);
      give_verdict();
   endtask

   // Address and data offered together, each released once taken
   task automatic wr(input ibf_addr_t a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      bready <= 1'b0;
      rs = bresp;
      if (n == 64)
         hang("write");
   endtask

   task automatic rd_reg(input ibf_addr_t a);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      rd = rdata;
      rs = rresp;
      rready <= 1'b0;
      if (n == 64)
         hang("read");
   endtask

   task automatic expect_reg(input string what, input ibf_addr_t a, input logic [7:0] m, input logic [7:0] e);
      rd_reg(a);
      chk(what, {24'h000000, e}, rd & {24'h000000, m});
   endtask

   // Waits for an output enable to reach a level
   task automatic wait_oe(input logic sda, input logic v);
      int n;
      for (n = 0; n < 2000; n++)
      begin
         @(posedge aclk);
         if ((sda ? sda_oe : scl_oe) === v)
            break;
      end
      if (n == 2000)
         hang(sda ? "sda_oe" : "scl_oe");
   endtask

   // Status reads have no side effects, so polling is safe
   task automatic poll(input int b, input logic v);
      int n;
      for (n = 0; n < 800; n++)
      begin
         rd_reg(a_ctl);
         if (rd[b] === v)
            break;
      end
      if (n == 800)
         hang("status poll");
   endtask

   task automatic t_reset();
      expect_reg("status", a_ctl, 8'h7F, 8'h00);
      expect_reg("config", a_cfg, 8'hFF, 8'h00);
      rd_reg(12'h000);
      chk("rresp", {30'h0, `IBF_RESP_SLVERR}, {30'h0, rs});
      wr(12'h000, 8'hFF);
      chk("bresp", {30'h0, `IBF_RESP_SLVERR}, {30'h0, rs});
   endtask

   task automatic t_slave_rx();
      ibf_peer_i.start_cond();
      expect_reg("start idle", a_ctl, 8'h7E, 8'h00);
      ibf_peer_i.send_bit(1'b1);
      expect_reg("rx one", a_ctl, 8'hFE, 8'hE0);
      ibf_peer_i.drive(1'b0, 1'b1);
      wait_oe(1'b0, 1'b1);
      expect_reg("data", a_dat, 8'hFF, 8'h80);
      wait_oe(1'b0, 1'b0);
      ibf_peer_i.send_bit(1'b0);
      expect_reg("no tx", a_ctl, 8'hFE, 8'h60);
      wr(a_ctl, 8'h20);
      expect_reg("ready clr", a_ctl, 8'h20, 8'h00);
   endtask

   // Ready cleared while a start is pending must not free SCL
   task automatic t_hold();
      ibf_peer_i.drive(1'b0, 1'b1);
      ibf_peer_i.drive(1'b1, 1'b1);
      ibf_peer_i.drive(1'b1, 1'b0);
      ibf_peer_i.drive(1'b0, 1'b0);
      wait_oe(1'b0, 1'b1);
      wr(a_ctl, 8'h20);
      repeat (20) @(posedge aclk);
      chk("scl held", 32'h1, {31'h0, scl_oe});
      expect_reg("start", a_ctl, 8'hFE, 8'hC8);
      wr(a_ctl, 8'h00);
      expect_reg("w0 keeps", a_ctl, 8'hFE, 8'hC8);
      wr(a_ctl, 8'h08);
      wait_oe(1'b0, 1'b0);
      expect_reg("start clr", a_ctl, 8'hFE, 8'h80);
   endtask

   task automatic t_slave_tx();
      ibf_peer_i.drive(1'b1, 1'b1);
      wr(a_dat, 8'h00);
      repeat (20) @(posedge aclk);
      chk("sda early", 32'h0, {31'h0, sda_oe});
      ibf_peer_i.drive(1'b0, 1'b1);
      wait_oe(1'b1, 1'b1);
      wr(a_ctl, 8'h80);
      wait_oe(1'b1, 1'b0);
      wr(a_dat, 8'h00);
      wait_oe(1'b1, 1'b1);
      rd_reg(a_dat);
      wait_oe(1'b1, 1'b0);
   endtask

   task automatic t_arb_stop_idle();
      wr(a_dat, 8'h80);
      ibf_peer_i.drive(1'b0, 1'b0);
      ibf_peer_i.drive(1'b1, 1'b0);
      expect_reg("arb lost", a_ctl, 8'hFE, 8'h70);
      wr(a_ctl, 8'h30);
      expect_reg("arb clr", a_ctl, 8'hFE, 8'h00);
      ibf_peer_i.drive(1'b0, 1'b0);
      ibf_peer_i.drive(1'b1, 1'b0);
      ibf_peer_i.drive(1'b1, 1'b1);
      expect_reg("stop", a_ctl, 8'hFE, 8'h64);
      wr(a_ctl, 8'h24);
      wr(a_ctl, 8'h40);
      ibf_peer_i.send_bit(1'b1);
      expect_reg("idle", a_ctl, 8'h7E, 8'h00);
   endtask

   task automatic t_master();
      repeat (500) @(posedge aclk);
      wr(a_cfg, 8'h01);
      poll(`IBF_RB_MST, 1'b1);
      wr(a_dat, 8'h80);
      poll(`IBF_RB_DATA_READY_FLAG, 1'b1);
      expect_reg("master", a_ctl, 8'hFE, 8'hE2);
      wait_oe(1'b0, 1'b1);
      wr(a_ctl, 8'h22);
      wait_oe(1'b1, 1'b1);
      wait_oe(1'b0, 1'b1);
      expect_reg("restart", a_ctl, 8'h3E, 8'h22);
      wr(a_cfg, 8'h00);
      wr(a_ctl, 8'h21);
      wait_oe(1'b1, 1'b1);
      poll(`IBF_RB_STP, 1'b1);
      expect_reg("master off", a_ctl, 8'h06, 8'h04);
      chk("sda free", 32'h0, {31'h0, sda_oe});
   endtask

   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_slave_rx();
      t_hold();
      t_slave_tx();
      t_arb_stop_idle();
      t_master();
      give_verdict();
   end
endmodule

// ---- hw/ibf_params.svh ----
`ifndef IBF_PARAMS_SVH
`define IBF_PARAMS_SVH

// Register indices and byte addresses
`define IBF_ADDR_W 12
`define IBF_IDX_CTRL 8'hD8
`define IBF_IDX_DATA 8'hD9
`define IBF_IDX_CFG 8'hDA
`define IBF_ADDR_CTRL {2'h0, `IBF_IDX_CTRL, 2'h0}
`define IBF_ADDR_DATA {2'h0, `IBF_IDX_DATA, 2'h0}
`define IBF_ADDR_CFG {2'h0, `IBF_IDX_CFG, 2'h0}

// Control/status read fields
`define IBF_RB_RBIT 7
`define IBF_RB_ATTN 6
`define IBF_RB_DATA_READY_FLAG 5
`define IBF_RB_ARL 4
`define IBF_RB_STR 3
`define IBF_RB_STP 2
`define IBF_RB_MST 1

// Control/status write fields
`define IBF_WB_CXA 7
`define IBF_WB_IDLE 6
`define IBF_WB_CDR 5
`define IBF_WB_CLEAR_ARB_LOST 4
`define IBF_WB_CLEAR_START_SEEN 3
`define IBF_WB_CLEAR_STOP_SEEN 2
`define IBF_WB_SEND_REPEATED_START 1
`define IBF_WB_SEND_STOP_REQUEST 0

// Data and config fields
`define IBF_DB_BIT 7
`define IBF_CB_OWNREQ 0

// Timing
`define IBF_CLK_NS 10
`define IBF_MIN_TIME_NS 4700
`define IBF_MIN_CYC ((`IBF_MIN_TIME_NS + `IBF_CLK_NS - 1) / `IBF_CLK_NS)
`define IBF_CNT_W 10
`define IBF_STOPCHK_CYC 3

// Bus responses
`define IBF_RESP_OKAY 2'h0
`define IBF_RESP_SLVERR 2'h2

`endif

// ---- hw/ibf_pkg.sv ----
`include "ibf_params.svh"
package ibf_pkg;
   // Master bit sequencer states
   typedef enum logic [4:0]
   {
      IBF_M_IDLE = 5'h01,
      IBF_M_START = 5'h02,
      IBF_M_LOW = 5'h04,
      IBF_M_HIGH = 5'h08,
      IBF_M_STOPCHK = 5'h10
   } ibf_mstate_t;
   typedef logic [`IBF_ADDR_W-1:0] ibf_addr_t;
   typedef logic [31:0] ibf_word_t;
   typedef logic [3:0] ibf_strb_t;
   typedef logic [1:0] ibf_resp_t;
endpackage

// ---- hw/ibf_top.sv ----
`timescale 1ns/1ps
`include "ibf_params.svh"
module ibf_top
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire ibf_pkg::ibf_addr_t s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire ibf_pkg::ibf_word_t s_axi_wdata,
   input wire ibf_pkg::ibf_strb_t s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output ibf_pkg::ibf_resp_t s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire ibf_pkg::ibf_addr_t s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output ibf_pkg::ibf_word_t s_axi_rdata,
   output ibf_pkg::ibf_resp_t s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic scl_i,
   output logic scl_o,
   output logic scl_oe,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe
);
   import ibf_pkg::*;

   // Pin synchronisers; the first stage is read only by the second
   logic scl_m, scl_s, scl_d;
   logic sda_m, sda_s, sda_d;

   // Bus slave state
   logic aw_held, next_aw_held;
   ibf_addr_t aw_addr, next_aw_addr;
   logic w_held, next_w_held;
   logic [7:0] w_byte, next_w_byte;
   logic w_lane0, next_w_lane0;
   logic bvalid, next_bvalid;
   ibf_resp_t bresp, next_bresp;
   logic rvalid, next_rvalid;
   logic [7:0] rbyte, next_rbyte;
   ibf_resp_t rresp, next_rresp;

   // Bit interface state
   logic data_ready_flag, next_data_ready_flag; // Data ready flag
   logic arb_lost_flag, next_arl; // Arbitration lost flag
   logic str, next_str; // Start seen flag
   logic stop_seen_flag, next_stp; // Stop seen flag
   logic rbit, next_rbit; // Received bit
   logic tx_active, next_tx_active; // Transmit active state
   logic xbit_pend, next_xbit_pend; // Bit written by software
   logic xbit_live, next_xbit_live; // Bit currently applied to SDA
   logic rstart_req, next_rstart_req; // Repeated start pending
   logic stop_req, next_stop_req; // Stop pending
   logic master, next_master; // Bus master status
   logic busy, next_busy; // Frame in progress on the bus
   logic idle, next_idle; // Slave ignoring the bus
   logic drop_master, next_drop_master; // Stop issued after request released
   logic owner_req, next_owner_req; // Bus owner request
   ibf_mstate_t mstate, next_mstate;
   logic [`IBF_CNT_W-1:0] cnt, next_cnt; // Timing counter of the sequencer
   logic next_scl_oe, next_sda_oe;

   // Decoded events
   logic scl_rise, scl_fall, start_det, stop_det;
   logic wr_fire, rd_fire, ctrl_wr, data_wr, cfg_wr, data_rd;
   logic attn, own_start, min_done, chk_done, stop_done, arl_set;
   logic [7:0] wb;

   // Open-drain pins only ever pull low
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;

   // Two-stage sync plus one history stage for edge detection
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         scl_m <= 1'b1;
         scl_s <= 1'b1;
         scl_d <= 1'b1;
         sda_m <= 1'b1;
         sda_s <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_m <= scl_i;
         scl_s <= scl_m;
         scl_d <= scl_s;
         sda_m <= sda_i;
         sda_s <= sda_m;
         sda_d <= sda_s;
      end
   end

   // Bus line events
   assign scl_rise = scl_s & ~scl_d;
   assign scl_fall = ~scl_s & scl_d;
   assign start_det = scl_s & scl_d & sda_d & ~sda_s;
   assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

   // Handshake outputs straight from holding state
   assign s_axi_awready = ~aw_held;
   assign s_axi_wready = ~w_held;
   assign s_axi_arready = ~rvalid;
   assign s_axi_bvalid = bvalid;
   assign s_axi_bresp = bresp;
   assign s_axi_rvalid = rvalid;
   assign s_axi_rresp = rresp;
   assign s_axi_rdata = {24'h000000, rbyte};

   // Write executes once address and data are both held
   assign wr_fire = aw_held & w_held & ~bvalid;
   assign rd_fire = s_axi_arvalid & ~rvalid;
   assign wb = w_byte;
   assign ctrl_wr = wr_fire & w_lane0 & (aw_addr == `IBF_ADDR_CTRL);
   assign data_wr = wr_fire & w_lane0 & (aw_addr == `IBF_ADDR_DATA);
   assign cfg_wr = wr_fire & w_lane0 & (aw_addr == `IBF_ADDR_CFG);
   assign data_rd = rd_fire & (s_axi_araddr == `IBF_ADDR_DATA);

   // Bus slave next state and read mux
   always_comb
   begin
      next_aw_held = (aw_held & ~wr_fire) | (~aw_held & s_axi_awvalid);
      next_aw_addr = aw_held ? aw_addr : s_axi_awaddr;
      next_w_held = (w_held & ~wr_fire) | (~w_held & s_axi_wvalid);
      next_w_byte = w_held ? w_byte : s_axi_wdata[7:0];
      next_w_lane0 = w_held ? w_lane0 : s_axi_wstrb[0];
      next_bvalid = wr_fire | (bvalid & ~s_axi_bready);
      next_bresp = bresp;
      next_rvalid = rd_fire | (rvalid & ~s_axi_rready);
      next_rbyte = rbyte;
      next_rresp = rresp;
      if (wr_fire)
      begin
         // Unmapped addresses answer with an error and change nothing
         if ((aw_addr == `IBF_ADDR_CTRL) || (aw_addr == `IBF_ADDR_DATA) || (aw_addr == `IBF_ADDR_CFG))
            next_bresp = `IBF_RESP_OKAY;
         else
            next_bresp = `IBF_RESP_SLVERR;
      end
      if (rd_fire)
      begin
         next_rresp = `IBF_RESP_OKAY;
         case (s_axi_araddr)
            `IBF_ADDR_CTRL:
               next_rbyte = {rbit, attn, data_ready_flag, arb_lost_flag, str, stop_seen_flag, master, 1'b0};
            `IBF_ADDR_DATA:
               next_rbyte = {rbit, 7'h00};
            `IBF_ADDR_CFG:
               next_rbyte = {7'h00, owner_req};
            default:
            begin
               next_rbyte = 8'h00;
               next_rresp = `IBF_RESP_SLVERR;
            end
         endcase
      end
   end

   // Bus slave registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `IBF_RESP_OKAY;
         rvalid <= 1'b0;
         rbyte <= 8'h00;
         rresp <= `IBF_RESP_OKAY;
      end
      else
      begin
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_byte <= next_w_byte;
         w_lane0 <= next_w_lane0;
         bvalid <= next_bvalid;
         bresp <= next_bresp;
         rvalid <= next_rvalid;
         rbyte <= next_rbyte;
         rresp <= next_rresp;
      end
   end

   // Shared status terms
   assign attn = data_ready_flag | arb_lost_flag | str | stop_seen_flag;
   assign own_start = (mstate == IBF_M_START);
   assign min_done = (cnt == `IBF_CNT_W'(`IBF_MIN_CYC - 1));
   assign chk_done = (cnt == `IBF_CNT_W'(`IBF_STOPCHK_CYC - 1));
   assign stop_done = (mstate == IBF_M_STOPCHK) & chk_done & sda_s;

   // Loss cases; each needs transmit active, so losing is impossible otherwise
   assign arl_set = tx_active & (
      (scl_rise & xbit_live & ~sda_s) |
      (start_det & xbit_live & ~own_start) |
      ((mstate == IBF_M_HIGH) & rstart_req & scl_fall) |
      ((mstate == IBF_M_STOPCHK) & chk_done & ~sda_s));

   // Flags, transmit state and master status
   always_comb
   begin
      // Hardware sets win over a clear in the same cycle
      next_arl = arl_set | (arb_lost_flag & ~(ctrl_wr & wb[`IBF_WB_CLEAR_ARB_LOST]));
      next_str = (start_det & (master | ~idle) & ~own_start)
         | (str & ~(ctrl_wr & wb[`IBF_WB_CLEAR_START_SEEN]));
      next_stp = (stop_det & (master | ~idle)) | (stop_seen_flag & ~(ctrl_wr & wb[`IBF_WB_CLEAR_STOP_SEEN]));
      next_data_ready_flag = (scl_rise & (master | ~idle))
         | (data_ready_flag & ~((ctrl_wr & wb[`IBF_WB_CDR]) | data_wr | data_rd));
      next_rbit = scl_rise ? sda_s : rbit;
      // Loss overrides every set, so the line is let go at once
      if (arl_set | arb_lost_flag)
         next_tx_active = 1'b0;
      else if (data_wr | (ctrl_wr & (wb[`IBF_WB_SEND_REPEATED_START] | wb[`IBF_WB_SEND_STOP_REQUEST])))
         next_tx_active = 1'b1;
      else if ((ctrl_wr & wb[`IBF_WB_CXA]) | data_rd | stop_done)
         next_tx_active = 1'b0;
      else
         next_tx_active = tx_active;
      // Bit to send next
      if (stop_done)
         next_xbit_pend = 1'b1;
      else if (ctrl_wr & wb[`IBF_WB_SEND_REPEATED_START])
         next_xbit_pend = 1'b1;
      else if (ctrl_wr & wb[`IBF_WB_SEND_STOP_REQUEST])
         next_xbit_pend = 1'b0;
      else if (data_wr)
         next_xbit_pend = wb[`IBF_DB_BIT];
      else
         next_xbit_pend = xbit_pend;
      // A bit written during SCL high waits for the low phase
      if (stop_done)
         next_xbit_live = 1'b1;
      else if (~tx_active)
         next_xbit_live = 1'b1; // Released while idle, so a stale 0 never reappears during SCL high
      else if (~scl_s)
         next_xbit_live = xbit_pend;
      else
         next_xbit_live = xbit_live;
      next_rstart_req = (ctrl_wr & wb[`IBF_WB_SEND_REPEATED_START])
         | (rstart_req & ~(arl_set | ((mstate == IBF_M_HIGH) & scl_s & min_done)));
      next_stop_req = (ctrl_wr & wb[`IBF_WB_SEND_STOP_REQUEST]) | (stop_req & ~(arl_set | stop_done));
      next_busy = start_det | (busy & ~stop_det);
      // Idle only applies to a slave; a start wakes it
      next_idle = (ctrl_wr & wb[`IBF_WB_IDLE] & ~master) | (idle & ~start_det);
      next_owner_req = cfg_wr ? wb[`IBF_CB_OWNREQ] : owner_req;
      next_drop_master = (ctrl_wr & wb[`IBF_WB_SEND_STOP_REQUEST] & ~owner_req) | (drop_master & master);
      // A free bus with the request raised grants mastership
      if (arl_set | (drop_master & stop_det))
         next_master = 1'b0;
      else if (owner_req & ~busy & ~start_det)
         next_master = 1'b1;
      else
         next_master = master;
   end

   // Master bit sequencer next state
   always_comb
   begin
      next_mstate = mstate;
      next_cnt = cnt;
      case (mstate)
         IBF_M_IDLE:
         begin
            next_cnt = '0;
            // Initial start is generated here, never by a software request
            if (master & tx_active & ~busy & ~arb_lost_flag)
               next_mstate = IBF_M_START;
         end
         IBF_M_START:
         begin
            // SDA held low for the minimum before SCL falls
            next_cnt = cnt + 1'b1;
            if (min_done)
            begin
               next_mstate = IBF_M_LOW;
               next_cnt = '0;
            end
         end
         IBF_M_LOW:
         begin
            if (!min_done)
               next_cnt = cnt + 1'b1;
            // Clearing every pending flag ends the low phase; a new bit gets a cycle of setup first
            else if (!attn && (!tx_active || (xbit_live == xbit_pend)))
            begin
               next_mstate = IBF_M_HIGH;
               next_cnt = '0;
            end
         end
         IBF_M_HIGH:
         begin
            if (!scl_s)
            begin
               // Waiting for the line to rise, or someone pulled it low early
               next_cnt = '0;
               if (scl_fall)
                  next_mstate = IBF_M_LOW;
            end
            else if (!min_done)
               next_cnt = cnt + 1'b1;
            else
            begin
               next_cnt = '0;
               if (rstart_req)
                  next_mstate = IBF_M_START;
               else if (stop_req)
                  next_mstate = IBF_M_STOPCHK;
               else
                  next_mstate = IBF_M_LOW;
            end
         end
         IBF_M_STOPCHK:
         begin
            // Let the released SDA settle through the synchroniser
            next_cnt = cnt + 1'b1;
            if (chk_done)
            begin
               next_mstate = IBF_M_IDLE;
               next_cnt = '0;
            end
         end
         default:
         begin
            next_mstate = IBF_M_IDLE;
            next_cnt = '0;
         end
      endcase
      // Loss or lost status abandons the sequence; SCL stays held once low while a flag is pending
      if (arl_set | ~master)
      begin
         next_mstate = IBF_M_IDLE;
         next_cnt = '0;
      end
   end

   // Pin drive computed from next values so pins track state
   always_comb
   begin
      // SDA low only while transmitting; the released phase of a stop overrides
      next_sda_oe = next_tx_active & (next_mstate != IBF_M_STOPCHK)
         & ((next_mstate == IBF_M_START) | ~next_xbit_live);
      // Once SCL is low, any pending flag keeps it low
      next_scl_oe = (next_mstate == IBF_M_LOW)
         | ((next_data_ready_flag | next_arl | next_str | next_stp) & (scl_oe | ~scl_s));
   end

   // Bit interface registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         data_ready_flag <= 1'b0;
         arb_lost_flag <= 1'b0;
         str <= 1'b0;
         stop_seen_flag <= 1'b0;
         rbit <= 1'b0;
         tx_active <= 1'b0;
         xbit_pend <= 1'b1;
         xbit_live <= 1'b1;
         rstart_req <= 1'b0;
         stop_req <= 1'b0;
         master <= 1'b0;
         busy <= 1'b0;
         idle <= 1'b1;
         drop_master <= 1'b0;
         owner_req <= 1'b0;
         mstate <= IBF_M_IDLE;
         cnt <= '0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
      end
      else
      begin
         data_ready_flag <= next_data_ready_flag;
         arb_lost_flag <= next_arl;
         str <= next_str;
         stop_seen_flag <= next_stp;
         rbit <= next_rbit;
         tx_active <= next_tx_active;
         xbit_pend <= next_xbit_pend;
         xbit_live <= next_xbit_live;
         rstart_req <= next_rstart_req;
         stop_req <= next_stop_req;
         master <= next_master;
         busy <= next_busy;
         idle <= next_idle;
         drop_master <= next_drop_master;
         owner_req <= next_owner_req;
         mstate <= next_mstate;
         cnt <= next_cnt;
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
      end
   end
endmodule
